/* File: logic/cslp_params.svh */
// Constants for the core sleep and wakeup controller
`ifndef CSLP_PARAMS_SVH
`define CSLP_PARAMS_SVH
`define CSLP_PRIO_W 8
`define CSLP_EVENT_RST 1'b0
`define CSLP_PC_W 32
`define CSLP_PC_STEP 32'h0000_0002
`endif

/* File: logic/cslp_pkg.sv */
// Types for the core sleep and wakeup controller
`include "cslp_params.svh"
package cslp_pkg;
   // Sleep level chosen on entry
   typedef enum logic {CSLP_LVL_LIGHT, CSLP_LVL_DEEP} cslp_level_t;
   // Mechanism that put the core to sleep
   typedef enum logic [1:0] {CSLP_CAUSE_NONE, CSLP_CAUSE_WFI, CSLP_CAUSE_WFE, CSLP_CAUSE_EXIT} cslp_cause_t;
   // Exception report from the interrupt controller
   typedef struct packed {
      logic pend_valid;
      logic enabled;
      logic [`CSLP_PRIO_W-1:0] prio;
      logic new_pend;
   } cslp_exc_t;
   // Mask and control bits of the core
   typedef struct packed {
      logic sleep_after_handler_bit;
      logic pending_raises_event_bit;
      logic deep_sleep_select_bit;
      logic interrupt_mask_bit;
      logic fault_mask_bit;
   } cslp_ctrl_t;
endpackage : cslp_pkg

/* File: logic/cslp_ctrl.sv */
// Sleep entry and wakeup control for a processor core
`timescale 1ns/10ps
`default_nettype none
`include "cslp_params.svh"
module cslp_ctrl #(
   parameter int PRIO_W = `CSLP_PRIO_W,
   parameter int PC_W = `CSLP_PC_W
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Instruction side strobes
   input wire logic wfi_exec_in,
   input wire logic wfe_exec_in,
   input wire logic send_event_in,
   input wire logic handler_return_in,
   input wire logic [PC_W-1:0] wait_pc_in,
   // Control and mask bits
   input wire cslp_pkg::cslp_ctrl_t ctrl_in,
   // Exception report
   input wire cslp_pkg::cslp_exc_t exc_in,
   input wire logic [PRIO_W-1:0] cur_prio_in,
   // Status outputs
   output logic sleeping_out,
   output cslp_pkg::cslp_level_t level_out,
   output logic event_latch_out,
   output logic take_exception_out,
   output logic resume_valid_out,
   output logic [PC_W-1:0] resume_pc_out,
   output logic thread_mode_out
);
   // Widths the logic can serve; the report struct fixes the priority width
   if (PRIO_W < 1 || PRIO_W != `CSLP_PRIO_W || PC_W < 2) begin : g_bad_width
      $error("cslp_ctrl: unsupported width");
   end

   typedef enum logic [1:0] {ST_RUN, ST_SLEEP} cslp_state_t;
   cslp_state_t state_reg;
   cslp_pkg::cslp_cause_t cause_reg;
   logic event_reg;
   logic [PC_W-1:0] pc_reg;
   logic higher_prio;
   logic enterable;
   logic wake_exc;
   logic wake_evt;
   logic wake;
   logic masked_wake;

   // Wake qualification from the exception report
   assign higher_prio = exc_in.pend_valid && exc_in.enabled && (exc_in.prio < cur_prio_in);
   assign enterable = higher_prio && !ctrl_in.interrupt_mask_bit && !ctrl_in.fault_mask_bit;
   assign masked_wake = higher_prio && ctrl_in.interrupt_mask_bit && !ctrl_in.fault_mask_bit;
   assign wake_exc = enterable || masked_wake;
   assign wake_evt = (cause_reg == cslp_pkg::CSLP_CAUSE_WFE) && (event_reg || send_event_in
      || (ctrl_in.pending_raises_event_bit && exc_in.new_pend));
   assign wake = (state_reg == ST_SLEEP) && (wake_exc || wake_evt);

   // Sleep state machine
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_RUN;
         cause_reg <= cslp_pkg::CSLP_CAUSE_NONE;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (wfi_exec_in) begin
                  state_reg <= ST_SLEEP;
                  cause_reg <= cslp_pkg::CSLP_CAUSE_WFI;
               end else if (wfe_exec_in && !event_reg) begin
                  state_reg <= ST_SLEEP;
                  cause_reg <= cslp_pkg::CSLP_CAUSE_WFE;
               end else if (handler_return_in && ctrl_in.sleep_after_handler_bit) begin
                  state_reg <= ST_SLEEP;
                  cause_reg <= cslp_pkg::CSLP_CAUSE_EXIT;
               end
            end
            ST_SLEEP: begin
               if (wake) begin
                  state_reg <= ST_RUN;
                  cause_reg <= cslp_pkg::CSLP_CAUSE_NONE;
               end
            end
            default: begin
               state_reg <= ST_RUN;
               cause_reg <= cslp_pkg::CSLP_CAUSE_NONE;
            end
         endcase
      end
   end

   // One-bit event latch; a set wins over the clear
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         event_reg <= `CSLP_EVENT_RST;
      end else if (send_event_in || (ctrl_in.pending_raises_event_bit && exc_in.new_pend)) begin
         event_reg <= 1'b1;
      end else if (state_reg == ST_RUN && wfe_exec_in && !wfi_exec_in) begin
         event_reg <= 1'b0;
      end else if (wake && cause_reg == cslp_pkg::CSLP_CAUSE_WFE) begin
         event_reg <= 1'b0;
      end
   end

   // Resume address capture
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pc_reg <= '0;
      end else if (state_reg == ST_RUN && (wfi_exec_in || wfe_exec_in)) begin
         pc_reg <= wait_pc_in + PC_W'(`CSLP_PC_STEP);
      end
   end

   // Registered outputs
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sleeping_out <= 1'b0;
         level_out <= cslp_pkg::CSLP_LVL_LIGHT;
         event_latch_out <= 1'b0;
         take_exception_out <= 1'b0;
         resume_valid_out <= 1'b0;
         resume_pc_out <= '0;
         thread_mode_out <= 1'b1;
      end else begin
         sleeping_out <= (state_reg == ST_SLEEP) && !wake;
         if (state_reg == ST_RUN) begin
            level_out <= ctrl_in.deep_sleep_select_bit ? cslp_pkg::CSLP_LVL_DEEP
               : cslp_pkg::CSLP_LVL_LIGHT;
         end
         event_latch_out <= event_reg;
         take_exception_out <= wake && enterable;
         resume_valid_out <= wake && !enterable && cause_reg != cslp_pkg::CSLP_CAUSE_EXIT;
         resume_pc_out <= pc_reg;
         if (handler_return_in) begin
            thread_mode_out <= 1'b1;
         end else if (wake && enterable) begin
            thread_mode_out <= 1'b0;
         end
      end
   end

   // Checks
   chk_wfi_sleeps: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_RUN && wfi_exec_in |=> state_reg == ST_SLEEP)
      else $error("wait-interrupt did not sleep");
   chk_wfe_latch_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_RUN && wfe_exec_in && !wfi_exec_in && event_reg && !send_event_in
      && !(ctrl_in.pending_raises_event_bit && exc_in.new_pend) && !handler_return_in
      |=> state_reg == ST_RUN && !event_reg)
      else $error("wait-event with latch set misbehaved");
   chk_exit_sleeps: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_RUN && handler_return_in && ctrl_in.sleep_after_handler_bit
      |=> state_reg == ST_SLEEP && thread_mode_out)
      else $error("handler exit did not sleep");
   chk_wfi_wake_cause: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_SLEEP && cause_reg != cslp_pkg::CSLP_CAUSE_WFE && !wake_exc
      |=> state_reg == ST_SLEEP)
      else $error("woke without exception");
   chk_masked_wake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_SLEEP && masked_wake |=> state_reg == ST_RUN && !take_exception_out)
      else $error("masked wake wrong");
   chk_wfe_exc_wake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_SLEEP && cause_reg == cslp_pkg::CSLP_CAUSE_WFE && enterable
      |=> state_reg == ST_RUN ##1 !sleeping_out)
      else $error("wait-event missed exception");
   chk_pend_event: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      ctrl_in.pending_raises_event_bit && exc_in.new_pend && state_reg == ST_SLEEP
      && cause_reg == cslp_pkg::CSLP_CAUSE_WFE |=> state_reg == ST_RUN)
      else $error("new pending did not wake");
   chk_level_sel: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_RUN ##1 state_reg == ST_SLEEP
      |-> level_out == ($past(ctrl_in.deep_sleep_select_bit) ? cslp_pkg::CSLP_LVL_DEEP
      : cslp_pkg::CSLP_LVL_LIGHT))
      else $error("sleep level wrong");
   chk_resume_pc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      resume_valid_out |-> resume_pc_out == pc_reg)
      else $error("resume address wrong");
   // Fault mask set keeps a wait-interrupt or handler-exit sleep asleep
   chk_fault_blocks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state_reg == ST_SLEEP && cause_reg != cslp_pkg::CSLP_CAUSE_WFE && ctrl_in.fault_mask_bit
      |=> state_reg == ST_SLEEP)
      else $error("woke with fault mask set");
   // Handler held off while the interrupt mask is set
   chk_handler_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      take_exception_out |-> !$past(ctrl_in.interrupt_mask_bit))
      else $error("handler entered while masked");
   // Entry leaves thread mode, unless a handler return arrives in the same cycle
   chk_entry_mode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      take_exception_out |-> !thread_mode_out)
      else $error("entry stayed in thread mode");
   cov_wfi: cover property (@(posedge sys_clk_in) disable iff (rst_in)
      cause_reg == cslp_pkg::CSLP_CAUSE_WFI && wake);
   cov_wfe_pend: cover property (@(posedge sys_clk_in) disable iff (rst_in)
      cause_reg == cslp_pkg::CSLP_CAUSE_WFE && exc_in.new_pend && wake);
   cov_exit: cover property (@(posedge sys_clk_in) disable iff (rst_in)
      cause_reg == cslp_pkg::CSLP_CAUSE_EXIT && wake);
   cov_masked: cover property (@(posedge sys_clk_in) disable iff (rst_in) wake && masked_wake);
endmodule : cslp_ctrl
`default_nettype wire

/* File: verification/cslp_irq_model.sv */
// Interrupt controller model reporting one pending exception
`timescale 1ns/10ps
`default_nettype none
module cslp_irq_model (
   // Clock
   input wire logic sys_clk_in,
   // Commands from the bench
   input wire logic raise_in,
   input wire logic clear_in,
   input wire logic enable_in,
   input wire logic [7:0] prio_in,
   // Report to the core
   output var cslp_pkg::cslp_exc_t exc_out
);
   initial exc_out = '0;
   // Pending level held until cleared, one new-pending pulse per raise
   always @(posedge sys_clk_in) begin
      exc_out.new_pend <= raise_in;
      if (raise_in) begin
         exc_out.pend_valid <= 1'b1;
         exc_out.enabled <= enable_in;
         exc_out.prio <= prio_in;
      end else if (clear_in) begin
         exc_out.pend_valid <= 1'b0;
         exc_out.enabled <= 1'b0; // Nothing pending, nothing enabled
      end
   end
endmodule : cslp_irq_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the sleep and wakeup controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module testbench;
   logic sys_clk = 0, rst = 1, wait_interrupt_instr = 0, wait_event_instr = 0, sev = 0, hret = 0, raise = 0, clr = 0, en = 0;
   logic [31:0] wpc = '0;
   logic [7:0] prio = '0, cur = 8'h40;
   cslp_pkg::cslp_ctrl_t ctrl = '0;
   cslp_pkg::cslp_exc_t exc;
   cslp_pkg::cslp_level_t lvl;
   logic slp, latch, take, resv, thr;
   logic [31:0] rpc;
   int failures = 0, n_checks = 0;
   bit s;
   // Clock
   always #50 sys_clk = ~sys_clk;
   cslp_irq_model u_cslp_irq_model (.sys_clk_in(sys_clk), .raise_in(raise), .clear_in(clr),
      .enable_in(en), .prio_in(prio), .exc_out(exc));
   cslp_ctrl u_cslp_ctrl (.sys_clk_in(sys_clk), .rst_in(rst), .wfi_exec_in(wait_interrupt_instr), .wfe_exec_in(wait_event_instr),
      .send_event_in(sev), .handler_return_in(hret), .wait_pc_in(wpc), .ctrl_in(ctrl), .exc_in(exc),
      .cur_prio_in(cur), .sleeping_out(slp), .level_out(lvl), .event_latch_out(latch),
      .take_exception_out(take), .resume_valid_out(resv), .resume_pc_out(rpc), .thread_mode_out(thr));
   // One-cycle strobe: 0 wfi, 1 wfe, 2 return, 3 event, 4 clear
   task strobe(input int k);
      @(posedge sys_clk);
      case (k)
         0: wait_interrupt_instr <= 1'b1;
         1: wait_event_instr <= 1'b1;
         2: hret <= 1'b1;
         3: sev <= 1'b1;
         default: clr <= 1'b1;
      endcase
      @(posedge sys_clk);
      {wait_interrupt_instr, wait_event_instr, hret, sev, clr} <= '0;
   endtask : strobe
   task raise_exc(input logic e, input logic [7:0] p);
      @(posedge sys_clk);
      {en, prio, raise} <= {e, p, 1'b1};
      @(posedge sys_clk);
      raise <= 1'b0;
   endtask : raise_exc
   task set_ctrl(input cslp_pkg::cslp_ctrl_t c, input logic [31:0] pc);
      @(posedge sys_clk);
      {ctrl, wpc} <= {c, pc};
   endtask : set_ctrl
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // Bounded wait: 0 entry pulse, 1 resume pulse, 2 awake
   task await(input int sel);
      s = 0;
      repeat (6) begin
         tick(1);
         if ((sel == 0 && take === 1'b1) || (sel == 1 && resv === 1'b1) || (sel == 2 && slp === 1'b0)) s = 1;
      end
   endtask : await
   task t_wfi;
      set_ctrl(5'b00100, 32'h0000_0100);
      strobe(0);
      tick(2);
      `CHK("sleeping", 1'b1, slp)
      `CHK("level", cslp_pkg::CSLP_LVL_DEEP, lvl)
      raise_exc(1'b1, 8'h80);
      tick(4);
      `CHK("sleep low prio", 1'b1, slp)
      raise_exc(1'b1, 8'h10);
      await(0);
      `CHK("entry", 1'b1, s)
      `CHK("thread", 1'b0, thr)
      strobe(4);
      $display("done wfi");
   endtask : t_wfi
   task t_exit;
      set_ctrl(5'b10000, 32'h0000_0100);
      strobe(2);
      tick(2);
      `CHK("exit sleep", 1'b1, slp)
      `CHK("exit thread", 1'b1, thr)
      `CHK("exit level", cslp_pkg::CSLP_LVL_LIGHT, lvl)
      raise_exc(1'b1, 8'h10);
      await(0);
      `CHK("exit entry", 1'b1, s)
      strobe(4);
      set_ctrl(5'b00000, 32'h0000_0100);
      strobe(2);
      tick(2);
      `CHK("return awake", 1'b0, slp)
      $display("done exit");
   endtask : t_exit
   task t_mask;
      set_ctrl(5'b00001, 32'h0000_0200);
      strobe(0);
      tick(2);
      raise_exc(1'b1, 8'h10);
      tick(4);
      `CHK("fault masked sleep", 1'b1, slp)
      set_ctrl(5'b00000, 32'h0000_0200);
      await(0);
      `CHK("unmasked entry", 1'b1, s)
      strobe(4);
      set_ctrl(5'b00010, 32'h0000_0200);
      strobe(0);
      tick(2);
      raise_exc(1'b1, 8'h10);
      await(1);
      `CHK("masked resume", 1'b1, s)
      `CHK("resume pc", 32'h0000_0202, rpc)
      `CHK("masked awake", 1'b0, slp)
      strobe(4);
      $display("done mask");
   endtask : t_mask
   task t_wfe;
      set_ctrl(5'b00000, 32'h0000_0300);
      strobe(3);
      tick(1);
      `CHK("latch set", 1'b1, latch)
      strobe(1);
      tick(3);
      `CHK("no sleep", 1'b0, slp)
      `CHK("latch clear", 1'b0, latch)
      strobe(1);
      tick(2);
      `CHK("wfe sleep", 1'b1, slp)
      raise_exc(1'b1, 8'h10);
      await(0);
      `CHK("wfe entry", 1'b1, s)
      strobe(4);
      $display("done wfe");
   endtask : t_wfe
   task t_sev;
      set_ctrl(5'b01000, 32'h0000_0400);
      strobe(1);
      tick(2);
      `CHK("sev sleep", 1'b1, slp)
      raise_exc(1'b0, 8'hff);
      await(2);
      `CHK("sev wake", 1'b1, s)
      `CHK("sev resume pc", 32'h0000_0402, rpc)
      strobe(4);
      $display("done sev");
   endtask : t_sev
   task summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // Watchdog
   initial begin
      repeat (1000) @(posedge sys_clk);
      failures++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_wfi();
      t_exit();
      t_mask();
      t_wfe();
      t_sev();
      summarize();
   end
endmodule : testbench
`default_nettype wire
